// >>> rcdc_assertions.sv
// Checker on control ports: bus answer, pulses, held settings.
// Assumes a bind to rcdc_top.
`timescale 1ns/1ps
module rcdc_assertions import rcdc_pkg::*; (
    input wire logic             sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq,
    input wire logic [AW-1:0]    avs_address,
    input wire logic [DW-1:0]    avs_writedata, avs_readdata,
    input wire logic [1:0]       cdr_rst,
    input wire logic [1:0][1:0]  vco_preset,
    input wire logic [1:0][2:0]  output_swing_setting);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    a_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("long wait");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h80 |-> avs_readdata == 32'h0)
        else $error("unmapped data");
    a_cdr_single: assert property (cdr_rst[0] |=> !cdr_rst[0]) else $error("long reset");
    a_cdr_start: assert property (
        avs_write && !avs_waitrequest && avs_address == REG_CTRL && avs_writedata[CTL_CDR_RST]
        |-> ##[1:2] cdr_rst[0]) else $error("no restart");
    a_preset_hold: assert property (
        !avs_write |=> $stable(vco_preset)) else $error("preset moved");
    a_swing_hold: assert property (
        !avs_write |=> $stable(output_swing_setting)) else $error("swing moved");
    a_irq_clear: assert property (
        $fell(irq) |-> $past(avs_write, 2) || $past(avs_write, 3)) else $error("irq fell");
endmodule

// >>> rcdc_partner.sv
// Far-side stand-in: reference, oscillator, recovery strobe, eye monitor.
// Assumes rate 0; merit falls as boost rises.
`timescale 1ns/1ps
module rcdc_partner import rcdc_pkg::*; (
    input wire logic             sys_clk, rst_n,
    input wire logic [1:0][3:0]  linear_equalizer_boost,
    output logic                 ref_tick,
    output logic [1:0]           vco_tick, sig_detect, rec_strobe, merit_valid, dfe_err, dfe_update,
    output logic [1:0][7:0]      merit_in);
    logic [1:0] ph_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) ph_r <= 2'h0;
        else ph_r <= ph_r + 2'h1;
    end
    assign ref_tick = ph_r == 2'h3;          // 256 oscillator ticks a window
    assign vco_tick = 2'h3;
    assign sig_detect = 2'h3;
    assign rec_strobe = {2{ph_r == 2'h1}};
    assign merit_valid = {2{ph_r == 2'h0}};
    assign merit_in[0] = 8'hC8 - {1'b0, linear_equalizer_boost[0], 3'h0};
    assign merit_in[1] = 8'hC8 - {1'b0, linear_equalizer_boost[1], 3'h0};
    assign dfe_err = {ph_r[1], ~ph_r[1]};
    assign dfe_update = {2{ph_r == 2'h2}};
endmodule

// >>> rcdc_pkg.sv
// Constants, register map and types shared by the retimer channel control.
// Assumes a 20 MHz system clock and byte addressing on the register bus.
package rcdc_pkg;

    localparam int CH_NUM        = 2;
    localparam int AW            = 8;
    localparam int DW            = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [AW-1:0] CH_STRIDE    = 8'h20;
    localparam logic [AW-1:0] REG_CTRL     = 8'h00;
    localparam logic [AW-1:0] REG_DRV      = 8'h04;
    localparam logic [AW-1:0] REG_STAT     = 8'h08;
    localparam logic [AW-1:0] REG_DFE      = 8'h0C;
    localparam logic [AW-1:0] REG_INT_STAT = 8'h40;
    localparam logic [AW-1:0] REG_INT_MASK = 8'h44;

    // Control register fields
    localparam int CTL_SRC_LO    = 0;
    localparam int CTL_PRBS_LONG = 2;
    localparam int CTL_PRBS_EN   = 3;
    localparam int CTL_RATE_LO   = 4;
    localparam int CTL_LB_LO     = 6;
    localparam int CTL_CDR_RST   = 9;
    localparam int CTL_ADAPT_EN  = 10;
    localparam int CTL_W         = 11;
    localparam logic [CTL_W-1:0] CTL_RESET = 11'h4C1;

    // Driver register fields
    localparam int DRV_SWING_LO  = 0;
    localparam int DRV_DEEMPH_LO = 3;
    localparam int DRV_SLEW      = 7;
    localparam int DRV_POL       = 8;
    localparam int DRV_W         = 9;
    localparam logic [DRV_W-1:0] DRV_RESET = 9'h002;

    // Status register fields
    localparam int ST_LOCK       = 0;
    localparam int ST_SIG        = 1;
    localparam int ST_STATE_LO   = 2;
    localparam int ST_BOOST_LO   = 8;
    localparam int ST_MERIT_LO   = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and sizes
    localparam int SWING_W       = 3;
    localparam int DEEMPH_W      = 4;
    localparam int RATE_W        = 2;
    localparam int LB_W          = 3;
    localparam int BOOST_W       = 4;
    localparam logic [BOOST_W-1:0] BOOST_MAX = 4'hF;
    localparam int MERIT_W       = 8;
    localparam int DFE_TAPS      = 5;
    localparam int TAP_W         = 5;
    localparam logic signed [TAP_W-1:0] TAP_POS_MAX = 5'sh0F;
    localparam logic signed [TAP_W-1:0] TAP_NEG_MAX = -5'sh10;
    localparam int EV_PER_CH     = 3;
    localparam int EV_W          = CH_NUM * EV_PER_CH;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int REF_CLK_HZ    = 25000000;
    localparam int EQ_SETTLE_NS  = 1000;
    localparam int EQ_SETTLE_CYC = (EQ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DFE_RUN_NS    = 4000;
    localparam int DFE_RUN_CYC   = (DFE_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 8;

    // Lock window in reference ticks and expected oscillator ticks per rate
    localparam int REF_WIN_W     = 6;
    localparam logic [REF_WIN_W-1:0] REF_WIN_LAST = 6'h3F;
    localparam int VCO_CNT_W     = 12;
    localparam logic [VCO_CNT_W-1:0] VCO_EXPECT [4] = '{12'h100, 12'h0C0, 12'h080, 12'h040};
    localparam logic [VCO_CNT_W-1:0] VCO_TOL     = 12'h002;

    ////////////////////////////////////////////////////////////////////////////////
    // Pattern generator
    localparam int PRBS_W        = 31;
    localparam logic [PRBS_W-1:0] PRBS_SEED = 31'h0000_01FF;
    localparam int P9_A = 8;
    localparam int P9_B = 4;
    localparam int P31_A = 30;
    localparam int P31_B = 27;

    typedef enum logic [1:0] {SRC_RAW, SRC_RETIMED, SRC_PRBS, SRC_LOOP} rcdc_src_t;
    typedef enum logic [2:0] {AD_IDLE, AD_WAIT_LOCK, AD_SETTLE, AD_MEASURE, AD_DFE,
                              AD_DONE} rcdc_adapt_t;

endpackage

// >>> rcdc_prbs.sv
// Pattern generator for one channel, short or long maximal-length sequence.
// Assumes enable and selection are steady register bits.
`timescale 1ns/1ps
module rcdc_prbs
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic long_sel,
    output logic      bit_r
);
    import rcdc_pkg::*;

    logic [PRBS_W-1:0] lfsr_r;
    logic              fb;

    // Feedback from x^9+x^5+1 or x^31+x^28+1
    always_comb begin
        fb = long_sel ? (lfsr_r[P31_A] ^ lfsr_r[P31_B]) : (lfsr_r[P9_A] ^ lfsr_r[P9_B]);
    end

    // Shift, reseed when idle or stuck at zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_r <= PRBS_SEED;
            bit_r  <= 1'b0;
        end else if (!enable || lfsr_r == '0) begin
            lfsr_r <= PRBS_SEED;
            bit_r  <= 1'b0;
        end else begin
            lfsr_r <= {lfsr_r[PRBS_W-2:0], fb};
            bit_r  <= fb;
        end
    end
endmodule

// >>> rcdc_top.sv
// Two-channel retimer control: adaptation, lock judgement, data mux, driver settings.
// Assumes all inputs synchronous to sys_clk; ref_tick is the sampled reference pulse.
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module rcdc_top
    import rcdc_pkg::*;
(
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst_n,
    input  wire logic [rcdc_pkg::AW-1:0]               avs_address,
    input  wire logic                                  avs_read,
    input  wire logic                                  avs_write,
    input  wire logic [rcdc_pkg::DW-1:0]               avs_writedata,
    output logic      [rcdc_pkg::DW-1:0]               avs_readdata,
    output logic                                       avs_waitrequest,
    output logic                                       irq,
    input  wire logic                                  ref_tick,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           vco_tick,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           sig_detect,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           raw_data,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           rec_strobe,
    input  wire logic [rcdc_pkg::CH_NUM-1:0][rcdc_pkg::MERIT_W-1:0] merit_in,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           merit_valid,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           dfe_err,
    input  wire logic [rcdc_pkg::CH_NUM-1:0]           dfe_update,
    output logic      [rcdc_pkg::CH_NUM-1:0]           out_data,
    output logic      [rcdc_pkg::CH_NUM-1:0]           cdr_rst,
    output logic      [rcdc_pkg::CH_NUM-1:0][rcdc_pkg::RATE_W-1:0]  vco_preset,
    output logic      [rcdc_pkg::CH_NUM-1:0][rcdc_pkg::BOOST_W-1:0] linear_equalizer_boost,
    output logic      [rcdc_pkg::CH_NUM-1:0][rcdc_pkg::DFE_TAPS*rcdc_pkg::TAP_W-1:0]
                                                       decision_feedback_equalizer_taps,
    output logic      [rcdc_pkg::CH_NUM-1:0][rcdc_pkg::SWING_W-1:0] output_swing_setting,
    output logic      [rcdc_pkg::CH_NUM-1:0][rcdc_pkg::DEEMPH_W-1:0] deemph_setting,
    output logic      [rcdc_pkg::CH_NUM-1:0]           slew_limited
);
    import rcdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus slave
    logic                          wait_r;
    logic [DW-1:0]                 rdata_r;
    logic [DW-1:0]                 rd_mux;
    logic                          acc_wr;
    logic [CH_NUM-1:0][CTL_W-1:0]  ctrl_r;
    logic [CH_NUM-1:0][DRV_W-1:0]  drv_r;
    logic [CH_NUM-1:0]             cdr_req_r;
    logic [EV_W-1:0]               int_stat_r;
    logic [EV_W-1:0]               int_mask_r;
    logic [EV_W-1:0]               ev;
    logic                          irq_r;
    logic [CH_NUM-1:0][DW-1:0]     stat_word;
    logic [CH_NUM-1:0][DW-1:0]     dfe_word;
    logic [CH_NUM-1:0]             retimed_bit;

    assign acc_wr          = avs_write & ~wait_r;
    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;
    assign irq             = irq_r;

    // One wait cycle, then a single cycle with waitrequest low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else if ((avs_read | avs_write) & wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = '0;
        for (int c = 0; c < CH_NUM; c++) begin
            if (avs_address == AW'(c * CH_STRIDE + REG_CTRL)) begin
                rd_mux = DW'(ctrl_r[c] & ~(CTL_W'(1) << CTL_CDR_RST));
            end
            if (avs_address == AW'(c * CH_STRIDE + REG_DRV)) begin
                rd_mux = DW'(drv_r[c]);
            end
            if (avs_address == AW'(c * CH_STRIDE + REG_STAT)) begin
                rd_mux = stat_word[c];
            end
            if (avs_address == AW'(c * CH_STRIDE + REG_DFE)) begin
                rd_mux = dfe_word[c];
            end
        end
        if (avs_address == REG_INT_STAT) begin
            rd_mux = DW'(int_stat_r);
        end
        if (avs_address == REG_INT_MASK) begin
            rd_mux = DW'(int_mask_r);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (avs_read & wait_r) begin
            rdata_r <= rd_mux;
        end
    end

    // Per-channel control and driver registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r    <= {CH_NUM{CTL_RESET}};
            drv_r     <= {CH_NUM{DRV_RESET}};
            cdr_req_r <= '0;
        end else begin
            for (int c = 0; c < CH_NUM; c++) begin
                cdr_req_r[c] <= 1'b0;
                if (acc_wr && avs_address == AW'(c * CH_STRIDE + REG_CTRL)) begin
                    ctrl_r[c]    <= avs_writedata[CTL_W-1:0] & ~(CTL_W'(1) << CTL_CDR_RST);
                    cdr_req_r[c] <= avs_writedata[CTL_CDR_RST];
                end
                if (acc_wr && avs_address == AW'(c * CH_STRIDE + REG_DRV)) begin
                    drv_r[c] <= avs_writedata[DRV_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, set wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_r <= '0;
            int_mask_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            if (acc_wr && avs_address == REG_INT_STAT) begin
                int_stat_r <= (int_stat_r & ~avs_writedata[EV_W-1:0]) | ev;
            end else begin
                int_stat_r <= int_stat_r | ev;
            end
            if (acc_wr && avs_address == REG_INT_MASK) begin
                int_mask_r <= avs_writedata[EV_W-1:0];
            end
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channels, independent except the loop source, which takes the other channel's retimed bit
    for (genvar g = 0; g < CH_NUM; g++) begin : g_ch
        logic [REF_WIN_W-1:0]     ref_cnt_r;
        logic [VCO_CNT_W-1:0]     vco_cnt_r;
        logic [VCO_CNT_W-1:0]     expect_cnt;
        logic                     trans_r;
        logic                     lock_r;
        logic                     raw_q_r;
        logic                     retimed_r;
        logic                     cdr_rst_r;
        logic                     lock_lost;
        logic                     win_end;
        logic                     in_range;
        rcdc_adapt_t              st_r;
        logic [BOOST_W-1:0]       boost_r;
        logic [BOOST_W-1:0]       best_boost_r;
        logic [MERIT_W-1:0]       best_merit_r;
        logic [LB_W-1:0]          beyond_r;
        logic [CNT_W-1:0]         wait_cnt_r;
        logic                     done_ev_r;
        logic                     improved;
        logic [DFE_TAPS-1:0]      hist_r;
        logic signed [TAP_W-1:0]  tap_r [DFE_TAPS];
        logic                     prbs_bit;
        logic                     mux_bit;
        logic [CTL_W-1:0]         ctl;

        assign ctl        = ctrl_r[g];
        assign expect_cnt = VCO_EXPECT[ctl[CTL_RATE_LO +: RATE_W]];
        assign win_end    = ref_tick && ref_cnt_r == REF_WIN_LAST;
        assign in_range   = (vco_cnt_r + VCO_TOL >= expect_cnt) &&
                            (vco_cnt_r <= expect_cnt + VCO_TOL);
        assign lock_lost  = win_end && lock_r && !(in_range && trans_r);

        // Oscillator count over a reference window, transitions required
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                ref_cnt_r <= '0;
                vco_cnt_r <= '0;
                trans_r   <= 1'b0;
                lock_r    <= 1'b0;
                raw_q_r   <= 1'b0;
            end else begin
                raw_q_r <= raw_data[g];
                if (cdr_rst_r) begin
                    ref_cnt_r <= '0;
                    vco_cnt_r <= '0;
                    trans_r   <= 1'b0;
                    lock_r    <= 1'b0;
                end else if (win_end) begin
                    ref_cnt_r <= '0;
                    vco_cnt_r <= '0;
                    trans_r   <= 1'b0;
                    lock_r    <= in_range && trans_r;
                end else begin
                    ref_cnt_r <= ref_cnt_r + REF_WIN_W'(ref_tick);
                    if (vco_tick[g] && vco_cnt_r != '1) begin
                        vco_cnt_r <= vco_cnt_r + VCO_CNT_W'(1);
                    end
                    if (raw_data[g] ^ raw_q_r) begin
                        trans_r <= 1'b1;
                    end
                end
            end
        end

        // Preset per rate, reset on request or on loss of lock
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                cdr_rst_r <= 1'b0;
            end else begin
                cdr_rst_r <= cdr_req_r[g] | lock_lost;
            end
        end

        // Retime on the recovered clock strobe
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                retimed_r <= 1'b0;
            end else if (rec_strobe[g]) begin
                retimed_r <= raw_data[g];
            end
        end

        assign improved = (merit_in[g] > best_merit_r) || (boost_r == '0);

        // Adaptation sequencer
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                st_r         <= AD_IDLE;
                boost_r      <= '0;
                best_boost_r <= '0;
                best_merit_r <= '0;
                beyond_r     <= '0;
                wait_cnt_r   <= '0;
                done_ev_r    <= 1'b0;
            end else begin
                done_ev_r <= 1'b0;
                if (cdr_rst_r) begin
                    st_r    <= AD_WAIT_LOCK;
                    boost_r <= '0;
                end else if (!sig_detect[g] || !ctl[CTL_ADAPT_EN]) begin
                    st_r <= AD_IDLE;
                end else begin
                    case (st_r)
                        AD_IDLE: begin
                            st_r <= AD_WAIT_LOCK;
                        end
                        AD_WAIT_LOCK: begin
                            if (lock_r) begin
                                boost_r      <= '0;
                                best_boost_r <= '0;
                                best_merit_r <= '0;
                                beyond_r     <= '0;
                                wait_cnt_r   <= '0;
                                st_r         <= AD_SETTLE;
                            end
                        end
                        AD_SETTLE: begin
                            wait_cnt_r <= wait_cnt_r + CNT_W'(1);
                            if (wait_cnt_r == CNT_W'(EQ_SETTLE_CYC - 1)) begin
                                st_r <= AD_MEASURE;
                            end
                        end
                        AD_MEASURE: begin
                            if (merit_valid[g]) begin
                                wait_cnt_r <= '0;
                                if (improved) begin
                                    best_merit_r <= merit_in[g];
                                    best_boost_r <= boost_r;
                                    beyond_r     <= '0;
                                end else begin
                                    beyond_r <= beyond_r + LB_W'(1);
                                end
                                if (!improved && beyond_r >= ctl[CTL_LB_LO +: LB_W]) begin
                                    boost_r <= best_boost_r;
                                    st_r    <= AD_DFE;
                                end else if (boost_r == BOOST_MAX) begin
                                    boost_r <= improved ? boost_r : best_boost_r;
                                    st_r    <= AD_DFE;
                                end else begin
                                    boost_r <= boost_r + BOOST_W'(1);
                                    st_r    <= AD_SETTLE;
                                end
                            end
                        end
                        AD_DFE: begin
                            wait_cnt_r <= wait_cnt_r + CNT_W'(1);
                            if (wait_cnt_r == CNT_W'(DFE_RUN_CYC - 1)) begin
                                done_ev_r <= 1'b1;
                                st_r      <= AD_DONE;
                            end
                        end
                        AD_DONE: begin
                            st_r <= AD_DONE;
                        end
                        default: begin
                            st_r <= AD_IDLE;
                        end
                    endcase
                end
            end
        end

        // Sign-sign tap adaptation after the linear stage, only in AD_DFE and AD_DONE
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                hist_r <= '0;
                for (int k = 0; k < DFE_TAPS; k++) begin
                    tap_r[k] <= '0;
                end
            end else if (cdr_rst_r) begin
                for (int k = 0; k < DFE_TAPS; k++) begin
                    tap_r[k] <= '0;
                end
            end else if (dfe_update[g] && (st_r == AD_DFE || st_r == AD_DONE)) begin
                hist_r <= {hist_r[DFE_TAPS-2:0], retimed_r};
                for (int k = 0; k < DFE_TAPS; k++) begin
                    if (dfe_err[g] ^ hist_r[k]) begin
                        if (tap_r[k] != TAP_NEG_MAX) begin
                            tap_r[k] <= tap_r[k] - TAP_W'(1);
                        end
                    end else if (tap_r[k] != TAP_POS_MAX) begin
                        tap_r[k] <= tap_r[k] + TAP_W'(1);
                    end
                end
            end
        end

        rcdc_prbs u_prbs (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .enable   (ctl[CTL_PRBS_EN]),
            .long_sel (ctl[CTL_PRBS_LONG]),
            .bit_r    (prbs_bit)
        );

        // Output source select
        always_comb begin
            case (rcdc_src_t'(ctl[CTL_SRC_LO +: 2]))
                SRC_RAW:     mux_bit = raw_q_r;
                SRC_RETIMED: mux_bit = retimed_r;
                SRC_PRBS:    mux_bit = prbs_bit;
                SRC_LOOP:    mux_bit = retimed_bit[CH_NUM - 1 - g];
                default:     mux_bit = retimed_r;
            endcase
        end

        logic out_r;
        // Polarity applied at the driver
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                out_r <= 1'b0;
            end else begin
                out_r <= mux_bit ^ drv_r[g][DRV_POL];
            end
        end

        assign retimed_bit[g]            = retimed_r;
        assign out_data[g]               = out_r;
        assign cdr_rst[g]                = cdr_rst_r;
        assign vco_preset[g]             = ctrl_r[g][CTL_RATE_LO +: RATE_W];
        assign linear_equalizer_boost[g] = boost_r;
        assign output_swing_setting[g]   = drv_r[g][DRV_SWING_LO +: SWING_W];
        assign deemph_setting[g]         = drv_r[g][DRV_DEEMPH_LO +: DEEMPH_W];
        assign slew_limited[g]           = drv_r[g][DRV_SLEW];
        for (genvar k = 0; k < DFE_TAPS; k++) begin : g_tap
            assign decision_feedback_equalizer_taps[g][k*TAP_W +: TAP_W] = tap_r[k];
        end

        assign ev[g*EV_PER_CH]     = win_end && !lock_r && in_range && trans_r && !cdr_rst_r;
        assign ev[g*EV_PER_CH + 1] = lock_lost && !cdr_rst_r;
        assign ev[g*EV_PER_CH + 2] = done_ev_r;

        assign stat_word[g] = DW'({best_merit_r, BOOST_W'(0), boost_r, 3'h0, st_r,
                                   sig_detect[g], lock_r});
        assign dfe_word[g]  = DW'(decision_feedback_equalizer_taps[g]);
    end
endmodule

// >>> tb.sv
// Bench for rcdc_top: registers, events, adaptation, data path.
// Assumes rcdc_partner on the far side.
`timescale 1ns/1ps
module tb;
    import rcdc_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic avs_waitrequest, irq, ref_tick;
    logic [AW-1:0] avs_address = 8'h00;
    logic [DW-1:0] avs_writedata = 32'h0, avs_readdata, rd, v0, v1;
    logic [1:0] vco_tick, sig_detect, raw_data = 2'h0, rec_strobe, merit_valid, dfe_err,
        dfe_update, out_data, cdr_rst, slew_limited, h_r;
    logic [1:0][7:0] merit_in;
    logic [1:0][1:0] vco_preset;
    logic [1:0][3:0] linear_equalizer_boost, deemph_setting;
    logic [1:0][2:0] output_swing_setting;
    logic [1:0][24:0] decision_feedback_equalizer_taps;
    int seed = 40437, failures = 0, check_count = 0, ones;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        raw_data <= 2'($random(seed));
        h_r <= {h_r[0], raw_data[0]};
    end
    rcdc_top uut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .irq, .ref_tick, .vco_tick, .sig_detect, .raw_data,
        .rec_strobe, .merit_in, .merit_valid, .dfe_err, .dfe_update, .out_data, .cdr_rst,
        .vco_preset, .linear_equalizer_boost, .decision_feedback_equalizer_taps,
        .output_swing_setting, .deemph_setting, .slew_limited);
    rcdc_partner far (.sys_clk, .rst_n, .linear_equalizer_boost, .ref_tick, .vco_tick,
        .sig_detect, .rec_strobe, .merit_in, .merit_valid, .dfe_err, .dfe_update);
    task automatic tally_and_finish();
        if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] e, input logic [DW-1:0] g, input string n);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic await_ev(input int b);
        do bus(1'b0, REG_INT_STAT, 32'h0); while (rd[b] !== 1'b1);
    endtask
    function automatic logic [DW-1:0] stat_exp(input logic [3:0] b);
        return {8'h00, 8'hC8 - {1'b0, b, 3'h0}, 4'h0, b, 3'h0, 3'h5, 2'h3};
    endfunction
    initial begin
        #(CLK_PERIOD_NS * 20000);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(CTL_RESET, rd, "ctrl");
        bus(1'b0, CH_STRIDE + REG_DRV, 32'h0);
        chk(DRV_RESET, rd, "drv");
        bus(1'b0, 8'h80, 32'h0);
        chk(32'h0, rd, "unmapped");
        v0 = $random(seed);
        v1 = $random(seed);
        bus(1'b1, REG_DRV, v0);
        bus(1'b1, CH_STRIDE + REG_DRV, v1);
        chk({v0[7:0], v1[7:0]}, {slew_limited[0], deemph_setting[0], output_swing_setting[0],
            slew_limited[1], deemph_setting[1], output_swing_setting[1]}, "drive");
        bus(1'b1, REG_INT_MASK, 32'h3F);
        await_ev(2);
        await_ev(5);
        for (int g = 0; g < 2; g++) begin
            bus(1'b0, (g ? CH_STRIDE : 8'h00) + REG_STAT, 32'h0);
            chk(stat_exp(4'h0), rd, "status");
            chk(32'h0, linear_equalizer_boost[g], "boost");
        end
        chk(1'b1, irq, "irq set");
        bus(1'b1, REG_INT_STAT, 32'h3F);
        bus(1'b0, REG_INT_MASK, 32'h0);
        chk(1'b0, irq, "irq clear");
        bus(1'b1, REG_INT_MASK, 32'h0);
        bus(1'b1, REG_CTRL, 32'h6C1);
        await_ev(2);
        chk(1'b0, irq, "irq masked");
        bus(1'b1, REG_INT_MASK, 32'h4);
        bus(1'b0, REG_STAT, 32'h0);
        chk(1'b1, irq, "irq unmasked");
        bus(1'b1, REG_CTRL, 32'h4C0);
        repeat (3) @(posedge sys_clk);
        repeat (16) begin
            @(negedge sys_clk);
            chk(h_r[1] ^ v0[8], out_data[0], "raw out");
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            bus(1'b1, REG_CTRL, m ? 32'h4CE : 32'h4CA);
            repeat (4) @(posedge sys_clk);
            ones = 0;
            repeat (511) begin
                @(negedge sys_clk);
                ones += int'(out_data[0] ^ v0[8]);
            end
            if (m == 0) chk(32'd256, ones, "short ones");
            else chk(1'b1, ones != 0, "long live");
        end
        tally_and_finish();
    end
endmodule
bind rcdc_top rcdc_assertions chk_i (.sys_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
    .irq, .avs_address, .avs_writedata, .avs_readdata, .cdr_rst, .vco_preset,
    .output_swing_setting);
